// >>> src/icu_regs.vh
`ifndef ICU_REGS_VH
`define ICU_REGS_VH
`define ICU_OFF_CTRL 8'h00
`define ICU_OFF_PFLAG1 8'h04
`define ICU_OFF_PFLAG2 8'h08
`define ICU_OFF_PEN1 8'h0c
`define ICU_OFF_PEN2 8'h10
`define ICU_OFF_ISTAT 8'h14
`define ICU_OFF_IMASK 8'h18
`define ICU_OFF_CORE 8'h1c
`define ICU_BIT_GLOBAL_EN 7
`define ICU_BIT_PEIE 6
`define ICU_BIT_T0IE 5
`define ICU_BIT_INTE 4
`define ICU_BIT_RBIE 3
`define ICU_BIT_T0IF 2
`define ICU_BIT_INTF 1
`define ICU_BIT_RBIF 0
`define ICU_CTRL_RST 8'h00
`define ICU_PERIPH_RST 4'h0
`define ICU_NPERIPH 8
`define ICU_VECTOR 13'h0004
`define ICU_LAT_CYCLES 3'h3
`define ICU_EV_TAKEN 0
`define ICU_EV_WAKE 1
`endif

// >>> src/icu_periph_bank.v
`timescale 1ns/1ps
`default_nettype none
`include "icu_regs.vh"
// one bank of four peripheral flags and enables
module icu_periph_bank (
    input wire core_clk,
    input wire rst,
    input wire [3:0] event_in,
    input wire flag_we,
    input wire [3:0] flag_wdata,
    input wire en_we,
    input wire [3:0] en_wdata,
    output reg [3:0] flag_reg,
    output reg [3:0] en_reg,
    output wire [3:0] req
);
    genvar i;
    generate
        for (i = 0; i < 4; i = i + 1) begin : g_src
            always @(posedge core_clk or posedge rst) begin
                if (rst) begin
                    flag_reg[i] <= 1'b0;
                    en_reg[i] <= 1'b0;
                end else begin
                    // event wins over a software clear in the same cycle
                    if (event_in[i])
                        flag_reg[i] <= 1'b1;
                    else if (flag_we)
                        flag_reg[i] <= flag_wdata[i];
                    if (en_we)
                        en_reg[i] <= en_wdata[i];
                end
            end
            assign req[i] = flag_reg[i] & en_reg[i];
        end
    endgenerate
endmodule
`default_nettype wire

// >>> src/icu_top.v
// Implementation choices: the Wishbone interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "icu_regs.vh"
module icu_top (
    input wire core_clk,
    input wire rst,
    input wire [7:0] wb_adr_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    input wire wb_we_i,
    input wire [3:0] wb_sel_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    output reg wb_ack_o,
    output wire wb_err_o,
    input wire ext_irq_pin,
    input wire port_change_evt,
    input wire base_timer_ovf,
    input wire [7:0] periph_evt,
    input wire instr_cycle_end,
    input wire return_from_irq_instr,
    input wire sleeping,
    input wire [12:0] pc_next,
    output wire irq_request,
    output wire wake_request,
    output reg irq_take,
    output reg stack_push,
    output reg [12:0] stack_push_addr,
    output reg pc_load,
    output reg [12:0] pc_load_value,
    output wire irq_out
);
    // =====================================
    // bus decode
    function is_write;
        input [7:0] adr;
        input [7:0] off;
        begin
            // a write lands at the edge where the master sees ack, not one edge earlier
            is_write = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0] && (adr == off);
        end
    endfunction

    reg [7:0] ctrl_reg;
    reg ext_pin_d_reg;
    reg [2:0] lat_cnt_reg;
    reg [1:0] istat_reg;
    reg [1:0] imask_reg;
    wire [3:0] pflag1, pflag2, pen1, pen2, preq1, preq2;
    wire any_periph;
    wire any_req;
    wire ext_edge;
    wire accept;
    wire wr_ctrl;

    assign wr_ctrl = is_write(wb_adr_i, `ICU_OFF_CTRL);
    assign wb_err_o = 1'b0;

    // =====================================
    // peripheral banks
    icu_periph_bank u_bank1 (
        .core_clk(core_clk),
        .rst(rst),
        .event_in(periph_evt[3:0]),
        .flag_we(is_write(wb_adr_i, `ICU_OFF_PFLAG1)),
        .flag_wdata(wb_dat_i[3:0]),
        .en_we(is_write(wb_adr_i, `ICU_OFF_PEN1)),
        .en_wdata(wb_dat_i[3:0]),
        .flag_reg(pflag1),
        .en_reg(pen1),
        .req(preq1)
    );
    icu_periph_bank u_bank2 (
        .core_clk(core_clk),
        .rst(rst),
        .event_in(periph_evt[7:4]),
        .flag_we(is_write(wb_adr_i, `ICU_OFF_PFLAG2)),
        .flag_wdata(wb_dat_i[3:0]),
        .en_we(is_write(wb_adr_i, `ICU_OFF_PEN2)),
        .en_wdata(wb_dat_i[3:0]),
        .flag_reg(pflag2),
        .en_reg(pen2),
        .req(preq2)
    );

    // =====================================
    // request combine
    assign ext_edge = ext_irq_pin & ~ext_pin_d_reg;
    assign any_periph = ctrl_reg[`ICU_BIT_PEIE] & (|{preq1, preq2});
    assign any_req = (ctrl_reg[`ICU_BIT_T0IF] & ctrl_reg[`ICU_BIT_T0IE])
        | (ctrl_reg[`ICU_BIT_INTF] & ctrl_reg[`ICU_BIT_INTE])
        | (ctrl_reg[`ICU_BIT_RBIF] & ctrl_reg[`ICU_BIT_RBIE])
        | any_periph;
    assign irq_request = any_req & ctrl_reg[`ICU_BIT_GLOBAL_EN];
    // wake does not look at the global enable
    assign wake_request = sleeping & any_req;
    // the counter runs in instruction cycles only, so instruction length never matters
    assign accept = irq_request && !sleeping && instr_cycle_end && (lat_cnt_reg == 3'h0);

    // =====================================
    // control register
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ctrl_reg <= `ICU_CTRL_RST;
            ext_pin_d_reg <= 1'b0;
        end else begin
            ext_pin_d_reg <= ext_irq_pin;
            if (wr_ctrl)
                ctrl_reg[6:3] <= wb_dat_i[6:3];
            if (accept)
                ctrl_reg[`ICU_BIT_GLOBAL_EN] <= 1'b0;
            else if (return_from_irq_instr)
                ctrl_reg[`ICU_BIT_GLOBAL_EN] <= 1'b1;
            else if (wr_ctrl)
                ctrl_reg[`ICU_BIT_GLOBAL_EN] <= wb_dat_i[`ICU_BIT_GLOBAL_EN];
            // hardware sets win over software writes
            ctrl_reg[`ICU_BIT_T0IF] <= base_timer_ovf |
                (wr_ctrl ? wb_dat_i[`ICU_BIT_T0IF] : ctrl_reg[`ICU_BIT_T0IF]);
            ctrl_reg[`ICU_BIT_INTF] <= ext_edge |
                (wr_ctrl ? wb_dat_i[`ICU_BIT_INTF] : ctrl_reg[`ICU_BIT_INTF]);
            ctrl_reg[`ICU_BIT_RBIF] <= port_change_evt |
                (wr_ctrl ? wb_dat_i[`ICU_BIT_RBIF] : ctrl_reg[`ICU_BIT_RBIF]);
        end
    end

    // =====================================
    // latency: ext flag sets one cycle after pin; take follows the third instr cycle end after the request, 2-3 instr cycles
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            lat_cnt_reg <= 3'h0;
        end else if (!irq_request) begin
            lat_cnt_reg <= `ICU_LAT_CYCLES - 3'h1;
        end else if (instr_cycle_end && lat_cnt_reg != 3'h0) begin
            lat_cnt_reg <= lat_cnt_reg - 3'h1;
        end
    end

    // =====================================
    // core handoff
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            irq_take <= 1'b0;
            stack_push <= 1'b0;
            stack_push_addr <= 13'h0000;
            pc_load <= 1'b0;
            pc_load_value <= 13'h0000;
        end else begin
            irq_take <= accept;
            stack_push <= accept;
            pc_load <= accept;
            if (accept) begin
                stack_push_addr <= pc_next;
                pc_load_value <= `ICU_VECTOR;
            end
        end
    end

    // =====================================
    // interrupt status
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            istat_reg <= 2'h0;
            imask_reg <= 2'h0;
        end else begin
            istat_reg[`ICU_EV_TAKEN] <= accept |
                (istat_reg[`ICU_EV_TAKEN] & ~(is_write(wb_adr_i, `ICU_OFF_ISTAT) & wb_dat_i[0]));
            istat_reg[`ICU_EV_WAKE] <= wake_request |
                (istat_reg[`ICU_EV_WAKE] & ~(is_write(wb_adr_i, `ICU_OFF_ISTAT) & wb_dat_i[1]));
            if (is_write(wb_adr_i, `ICU_OFF_IMASK))
                imask_reg <= wb_dat_i[1:0];
        end
    end
    assign irq_out = |(istat_reg & imask_reg);

    // =====================================
    // wishbone slave: ack one cycle after strobe
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
            case (wb_adr_i)
                `ICU_OFF_CTRL: wb_dat_o <= {24'h000000, ctrl_reg};
                `ICU_OFF_PFLAG1: wb_dat_o <= {28'h0000000, pflag1};
                `ICU_OFF_PFLAG2: wb_dat_o <= {28'h0000000, pflag2};
                `ICU_OFF_PEN1: wb_dat_o <= {28'h0000000, pen1};
                `ICU_OFF_PEN2: wb_dat_o <= {28'h0000000, pen2};
                `ICU_OFF_ISTAT: wb_dat_o <= {30'h00000000, istat_reg};
                `ICU_OFF_IMASK: wb_dat_o <= {30'h00000000, imask_reg};
                `ICU_OFF_CORE: wb_dat_o <= {29'h00000000, sleeping, wake_request, irq_request};
                default: wb_dat_o <= 32'h0000_0000;
            endcase
        end
    end
endmodule
`default_nettype wire

// >>> verif/icu_top_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module icu_top_asserts (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic wb_err_o,
    input wire logic instr_cycle_end,
    input wire logic sleeping,
    input wire logic irq_request,
    input wire logic wake_request,
    input wire logic irq_take,
    input wire logic stack_push,
    input wire logic pc_load,
    input wire logic [12:0] pc_next,
    input wire logic [12:0] stack_push_addr,
    input wire logic [12:0] pc_load_value
);
    logic acc_reg;
    // =========================================
    // helper: request at cycle end while awake, one edge back, without the latency count
    always @(posedge core_clk or posedge rst) begin
        if (rst) acc_reg <= 1'b0;
        else acc_reg <= irq_request && instr_cycle_end && !sleeping;
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    sequence take_s;
        irq_take && stack_push && pc_load;
    endsequence
    chk_take_cause: assert property (irq_take |-> acc_reg)
        else $error("take without enabled request at cycle end");
    chk_take_steps: assert property (irq_take |-> take_s ##1 !irq_take)
        else $error("acceptance pulses wrong");
    chk_gie_cleared: assert property (irq_take |-> !irq_request)
        else $error("request stays after acceptance");
    chk_vector_load: assert property (pc_load |-> pc_load_value == 13'h0004 && stack_push_addr == $past(pc_next))
        else $error("bad vector or return address");
    chk_latency_bound: assert property ($rose(irq_request) && !sleeping |-> ##[1:16] (irq_take || !irq_request))
        else $error("request not taken in time");
    chk_wake_sleep: assert property (wake_request |-> sleeping)
        else $error("wake while awake");
    chk_reset_gie: assert property ($fell(rst) |-> !irq_request && !irq_take)
        else $error("request right after reset");
    chk_ack_pulse: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
        else $error("bus ack not a one-cycle answer");
    chk_err_low: assert property (!wb_err_o)
        else $error("bus error raised");
endmodule
bind icu_top icu_top_asserts icu_top_asserts_i (.core_clk, .rst, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .wb_err_o,
    .instr_cycle_end, .sleeping, .irq_request, .wake_request, .irq_take, .stack_push, .pc_load, .pc_next,
    .stack_push_addr, .pc_load_value);
`default_nettype wire

// >>> verif/icu_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module icu_core_model (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic rfi_cmd,
    input wire logic sleep_cmd,
    input wire logic wake_request,
    input wire logic pc_load,
    input wire logic [12:0] pc_load_value,
    output wire logic instr_cycle_end,
    output logic return_from_irq_instr,
    output logic sleeping,
    output logic [12:0] pc_next
);
    logic [1:0] q_reg;
    // four clocks per instruction cycle, whatever the instruction length
    assign instr_cycle_end = (q_reg == 2'h3);
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            q_reg <= 2'h0;
            pc_next <= 13'h0000;
            sleeping <= 1'b0;
            return_from_irq_instr <= 1'b0;
        end else begin
            q_reg <= q_reg + 2'h1;
            return_from_irq_instr <= rfi_cmd;
            if (pc_load) pc_next <= pc_load_value + 13'h0001;
            else if (instr_cycle_end && !sleeping) pc_next <= pc_next + 13'h0001;
            sleeping <= (sleeping | sleep_cmd) & ~wake_request;
        end
    end
endmodule
`default_nettype wire

// >>> verif/tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin err_count++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, a, e); end end
module tb;
    logic core_clk = 0, rst = 1, we = 0, cyc = 0, stb = 0, ret_cmd = 0, slp = 0;
    logic [7:0] adr = 0;
    logic [31:0] wdat = 0, rd, dat_o;
    logic [3:0] sel = 0;
    logic [10:0] ev = 0;
    logic ack, err, icend, rfi, sleeping, irq_req, wake, take, push, pcl, irq_out;
    logic [12:0] pcn, spa, plv;
    int err_count = 0, checks = 0, n;
    initial forever #4 core_clk = ~core_clk;
    icu_top icu_top_i (.core_clk, .rst, .wb_adr_i(adr), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_we_i(we),
        .wb_sel_i(sel), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_ack_o(ack), .wb_err_o(err), .ext_irq_pin(ev[10]),
        .port_change_evt(ev[9]), .base_timer_ovf(ev[8]), .periph_evt(ev[7:0]), .instr_cycle_end(icend),
        .return_from_irq_instr(rfi), .sleeping, .pc_next(pcn), .irq_request(irq_req), .wake_request(wake),
        .irq_take(take), .stack_push(push), .stack_push_addr(spa), .pc_load(pcl), .pc_load_value(plv), .irq_out);
    icu_core_model icu_core_model_i (.core_clk, .rst, .rfi_cmd(ret_cmd), .sleep_cmd(slp), .wake_request(wake),
        .pc_load(pcl), .pc_load_value(plv), .instr_cycle_end(icend), .return_from_irq_instr(rfi), .sleeping,
        .pc_next(pcn));
    // =========================================
    // bus and event tasks
    task automatic bus(input [7:0] a, input [31:0] d, input w, input [3:0] s);
        @(posedge core_clk);
        adr <= a; wdat <= d; we <= w; sel <= s; cyc <= 1; stb <= 1;
        do @(posedge core_clk); while (ack !== 1'b1);
        rd = dat_o;
        cyc <= 0; stb <= 0; we <= 0;
        // let the write of the ack edge settle before anyone looks at outputs
        @(negedge core_clk);
    endtask
    task automatic wr(input [7:0] a, input [7:0] d); bus(a, {24'h0, d}, 1, 4'h1); endtask
    task automatic rdc(input [7:0] a, input [31:0] e); bus(a, 0, 0, 4'hf); `CHK(rd, e) endtask
    task automatic pulse(input [10:0] v); @(posedge core_clk); ev <= v; @(posedge core_clk); ev <= 0; endtask
    task stop_test;
        if (err_count == 0 && checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial begin
        #80000;
        err_count++;
        stop_test;
    end
    // =========================================
    // scenarios
    initial begin
        repeat (2) @(posedge core_clk);
        rst <= 0;
        rdc(8'h00, 32'h0);
        pulse(11'h700);
        rdc(8'h00, 32'h07);
        `CHK(irq_req, 1'b0)
        pulse(11'h081);
        rdc(8'h04, 32'h1);
        rdc(8'h08, 32'h8);
        wr(8'h0c, 8'h01);
        wr(8'h00, 8'h80);
        `CHK(irq_req, 1'b0)
        wr(8'h18, 8'h01);
        wr(8'h00, 8'hc0);
        `CHK(irq_req, 1'b1)
        rdc(8'h1c, 32'h1);
        n = 0;
        while (take !== 1'b1 && n < 40) begin @(posedge core_clk); n++; end
        `CHK(n <= 16, 1'b1)
        `CHK(plv, 13'h0004)
        rdc(8'h00, 32'h40);
        rdc(8'h14, 32'h1);
        `CHK(irq_out, 1'b1)
        wr(8'h18, 8'h00);
        `CHK(irq_out, 1'b0)
        wr(8'h14, 8'h01);
        rdc(8'h14, 32'h0);
        wr(8'h04, 8'h00);
        @(posedge core_clk) ret_cmd <= 1;
        @(posedge core_clk) ret_cmd <= 0;
        rdc(8'h00, 32'hc0);
        do begin wr(8'h00, 8'h40); bus(8'h00, 0, 0, 4'hf); end while (rd[7] !== 1'b0);
        `CHK(rd[7:0], 8'h40)
        wr(8'h00, 8'h20);
        @(posedge core_clk) slp <= 1;
        @(posedge core_clk) slp <= 0;
        pulse(11'h100);
        rdc(8'h14, 32'h2);
        rdc(8'h00, 32'h24);
        bus(8'h00, 32'hff, 1, 4'he);
        rdc(8'h00, 32'h24);
        rdc(8'h40, 32'h0);
        stop_test;
    end
endmodule
`default_nettype wire
